// file: core/srvsel_pkg.sv
// Constants for the servo input selector: register map, field layout,
// reset values and timing counts.
// Assumes a 32-bit APB bus with byte addresses and a 200 MHz pclk.
package srvsel_pkg;
   // Register byte offsets
   localparam logic [11:0] CTRL_OFS     = 12'h000; // Polarity, limit enable
   localparam logic [11:0] WEIGHT_OFS   = 12'h004; // Pulse scaling weight
   localparam logic [11:0] STATUS_OFS   = 12'h008; // Read-only state
   localparam logic [11:0] INT_STAT_OFS = 12'h00C; // Sticky events, W1C
   localparam logic [11:0] INT_MASK_OFS = 12'h010; // Event enables

   // Logical input bit positions
   localparam int B_ERR   = 0;  // Error clear request
   localparam int B_SERVO = 1;  // Servo-on request
   localparam int B_POSW0 = 2;  // Settling width select, low bit
   localparam int B_POSW1 = 3;  // Settling width select, high bit
   localparam int B_GAIN  = 4;  // Velocity bandwidth select
   localparam int B_FN    = 5;  // Position bandwidth select
   localparam int B_PLS   = 6;  // Pulse weight bypass
   localparam int B_POSITION_INTEGRAL_DISABLE  = 7;  // Position integral disable
   localparam int NIN     = 8;  // Number of contact inputs

   // CTRL fields
   localparam int CTRL_POL_LSB = 0;  // Polarity bits [7:0], 1 = negative
   localparam int CTRL_LIM_BIT = 8;  // External current limit enable

   // STATUS fields
   localparam int ST_SERVO_BIT = 8;  // Actual servo state
   localparam int ST_MULTI_BIT = 9;  // Multi-channel serial mode
   localparam int ST_ID_LSB    = 10; // Station id [13:10]
   localparam int ST_BAD_BIT   = 14; // Station id above nine
   localparam int ST_DONE_BIT  = 15; // Station id captured

   // Interrupt event bits
   localparam int EV_SERVO = 0;  // Servo state changed
   localparam int EV_CLEAR = 1;  // Error clear issued
   localparam int EV_SEL   = 2;  // Bandwidth or width selection changed
   localparam int NEV      = 3;

   // Reset values
   localparam logic [7:0]  POL_RST    = 8'h00;    // All positive
   localparam logic        LIM_RST    = 1'b0;     // Limit input disabled
   localparam logic [15:0] WEIGHT_RST = 16'h0001; // Plain default
   localparam logic [15:0] STEP_ONE   = 16'h0001; // Bypassed pulse weight
   localparam logic [7:0]  LIM_FULL   = 8'hFF;    // Full-scale limit
   localparam logic [3:0]  ID_MAX     = 4'h9;     // Highest ring station

   // Cycles after reset before the id switch sample is trusted
   localparam logic [1:0]  ID_WAIT    = 2'h3;
endpackage : srvsel_pkg

// file: core/srvsel_sync.sv
// Two-flop synchroniser for a bundle of unrelated level inputs.
// Assumes each bit is a slow level; bits are not coherent as a word.
`timescale 1ns/10ps
module srvsel_sync #(
   parameter int W = 1
) (
   input  wire logic         pclk,
   input  wire logic         presetn,
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);
   logic [W-1:0] meta_reg; // First stage, read only by second stage

   // Plain two-stage capture
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_reg <= '0;
         sync_out <= '0;
      end else begin
         meta_reg <= async_in;
         sync_out <= meta_reg;
      end
   end
endmodule : srvsel_sync

// file: core/srvsel_top.sv
// Servo input selector: contact inputs to parameter selections, servo
// gating, error clear requests, current limit gating, station id mode.
// Assumes contact pins, panel switch and id switch are asynchronous;
// drive_idle and the digitised limit value come from pclk logic.
//
// Summary of operation
// RULE_01: Bypass input makes each pulse weigh one.
// RULE_02: Position bandwidth set chosen by select input.
// RULE_03: Velocity bandwidth set chosen by select input.
// RULE_04: Two-bit code picks one of four widths.
// RULE_05: Integral disable input suspends position integral.
// RULE_06: Error clear request acted on only when idle.
// RULE_07: Controller should not hold error clear asserted.
// RULE_08: Servo on needs request and panel permission.
// RULE_09: External limit applied only when enabled.
// RULE_10: Point-to-point or ring of up to nine.
// RULE_11: Id switch zero at power-up: single channel.
// RULE_12: Ring drivers take ids one to nine.
// RULE_13: No link between id and ring position.
// RULE_14: Per-bit polarity maps contacts to logical inputs.
// RULE_15: Contacts synchronised before steering any selection.
//
// The address map and the APB interface to the registers were left to the implementer.
`timescale 1ns/10ps
module srvsel_top
   import srvsel_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        err_clear_contact,
   input  wire logic        servo_on_contact,
   input  wire logic [1:0]  settling_width_contact,
   input  wire logic        velocity_bandwidth_contact,
   input  wire logic        position_bandwidth_contact,
   input  wire logic        pulse_weight_bypass_contact,
   input  wire logic        position_integral_contact,
   input  wire logic        panel_servo_disable_switch,
   input  wire logic [3:0]  station_id_switch,
   input  wire logic        drive_idle,
   input  wire logic [7:0]  external_current_limit_input,
   output logic             pulse_weight_bypass,
   output logic             position_bandwidth_select,
   output logic             velocity_bandwidth_select,
   output logic [1:0]       settling_width_select,
   output logic             position_integral_disable,
   output logic             servo_on,
   output logic             error_clear_pulse,
   output logic [15:0]      cmd_step,
   output logic [7:0]       current_limit,
   output logic             multi_channel,
   output logic [3:0]       station_id,
   output logic             station_id_valid,
   output logic             irq
);
   import srvsel_pkg::*;

   // Whole block state
   typedef struct packed {
      logic [7:0]     polarity;  // 1 = negative logic
      logic           lim_en;    // External limit enable
      logic [15:0]    weight;    // Scaling weight per pulse
      logic [NEV-1:0] int_stat;  // Sticky events
      logic [NEV-1:0] int_mask;  // Event enables
      logic [7:0]     logic_in;  // Logical inputs
      logic           panel_dis; // Synchronised panel switch
      logic           servo_on;  // Actual servo state
      logic           clr_done;  // Clear issued for this request
      logic           err_clr;   // One-cycle clear strobe
      logic [15:0]    step;      // Weight of one incoming pulse
      logic [7:0]     cur_lim;   // Applied current limit
      logic [1:0]     id_cnt;    // Settle counter for id sample
      logic           id_done;   // Id captured
      logic [3:0]     id;        // Captured station id
      logic           id_bad;    // Id above nine
   } srvsel_s;

   srvsel_s s_reg;   // Registered state
   srvsel_s s_next;  // Next state

   logic [NIN-1:0] contact_raw;  // Raw contacts in logical bit order
   logic [NIN-1:0] contact_sync; // Synchronised contacts
   logic           panel_sync;   // Synchronised panel switch
   logic [3:0]     id_sync;      // Synchronised id switch
   logic [NIN-1:0] logic_next;   // Contacts after polarity
   logic           acc;          // APB access phase
   logic           wr;           // APB write strobe
   logic           mapped;       // Address hits a register
   logic [NEV-1:0] ev;           // Events this cycle
   logic [31:0]    status_word;  // STATUS read value

   assign contact_raw = {position_integral_contact,
                         pulse_weight_bypass_contact,
                         position_bandwidth_contact,
                         velocity_bandwidth_contact,
                         settling_width_contact,
                         servo_on_contact,
                         err_clear_contact};

   // Contact, panel and id switch pins cross into pclk here first; bits may skew by a cycle
   srvsel_sync #(.W(NIN + 5)) u_sync (
      .pclk     (pclk),
      .presetn  (presetn),
      .async_in ({station_id_switch, panel_servo_disable_switch,
                  contact_raw}),
      .sync_out ({id_sync, panel_sync, contact_sync})
   ); // RULE_15

   // Bus decode; slave never waits
   assign acc     = psel & penable;
   assign wr      = acc & pwrite;
   assign pready  = 1'b1;
   assign mapped  = (paddr == CTRL_OFS) | (paddr == WEIGHT_OFS) |
                    (paddr == STATUS_OFS) | (paddr == INT_STAT_OFS) |
                    (paddr == INT_MASK_OFS);
   assign pslverr = acc & ~mapped;

   // Status word assembled from state flops
   always_comb begin
      status_word = '0;
      status_word[NIN-1:0]     = s_reg.logic_in;
      status_word[ST_SERVO_BIT] = s_reg.servo_on;
      status_word[ST_MULTI_BIT] = multi_channel;
      status_word[ST_ID_LSB+:4] = s_reg.id;
      status_word[ST_BAD_BIT]   = s_reg.id_bad;
      status_word[ST_DONE_BIT]  = s_reg.id_done;
   end

   // Read mux; unmapped reads return zero with an error
   always_comb begin
      prdata = '0;
      unique case (paddr)
         CTRL_OFS: begin
            prdata[CTRL_POL_LSB+:8] = s_reg.polarity;
            prdata[CTRL_LIM_BIT]    = s_reg.lim_en;
         end
         WEIGHT_OFS:   prdata[15:0]    = s_reg.weight;
         STATUS_OFS:   prdata          = status_word;
         INT_STAT_OFS: prdata[NEV-1:0] = s_reg.int_stat;
         INT_MASK_OFS: prdata[NEV-1:0] = s_reg.int_mask;
         default:      prdata          = '0;
      endcase
   end

   // Next-state logic for the whole block
   always_comb begin
      s_next = s_reg;
      // Polarity applied to synchronised contacts only
      logic_next = contact_sync ^ s_reg.polarity; // RULE_14 RULE_15
      s_next.logic_in  = logic_next;
      s_next.panel_dis = panel_sync;
      // Panel switch can veto but never force servo on
      s_next.servo_on = logic_next[B_SERVO] & ~panel_sync; // RULE_08
      // One strobe per request, and only while idle; a request held
      // through busy time fires once idle arrives
      s_next.err_clr = s_reg.logic_in[B_ERR] & drive_idle &
                       ~s_reg.clr_done; // RULE_06
      s_next.clr_done = s_reg.logic_in[B_ERR] &
                        (s_reg.clr_done | s_next.err_clr);
      // Bypass: each pulse counts as one, weight ignored
      s_next.step = logic_next[B_PLS] ? STEP_ONE
                                      : s_reg.weight; // RULE_01
      // Limit input passes only when enabled, else full scale
      s_next.cur_lim = s_reg.lim_en ? external_current_limit_input
                                    : LIM_FULL; // RULE_09
      // Id sampled once after reset, never again until next reset
      if (!s_reg.id_done) begin
         if (s_reg.id_cnt == ID_WAIT) begin
            s_next.id_done = 1'b1;
            s_next.id      = id_sync; // RULE_11 RULE_12
            s_next.id_bad  = id_sync > ID_MAX; // RULE_12
         end else begin
            s_next.id_cnt = s_reg.id_cnt + 2'h1;
         end
      end
      // Events
      ev = '0;
      ev[EV_SERVO] = s_next.servo_on ^ s_reg.servo_on;
      ev[EV_CLEAR] = s_next.err_clr;
      ev[EV_SEL]   = |(logic_next[B_FN:B_POSW0] ^
                       s_reg.logic_in[B_FN:B_POSW0]);
      // Register writes
      if (wr) begin
         unique case (paddr)
            CTRL_OFS: begin
               s_next.polarity = pwdata[CTRL_POL_LSB+:8];
               s_next.lim_en   = pwdata[CTRL_LIM_BIT];
            end
            WEIGHT_OFS:   s_next.weight   = pwdata[15:0];
            INT_STAT_OFS: s_next.int_stat = s_reg.int_stat &
                                            ~pwdata[NEV-1:0];
            INT_MASK_OFS: s_next.int_mask = pwdata[NEV-1:0];
            default: ;
         endcase
      end
      // Set wins over a clear in the same cycle
      s_next.int_stat = s_next.int_stat | ev;
   end

   // State register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_reg          <= '0;
         s_reg.polarity <= POL_RST;
         s_reg.lim_en   <= LIM_RST; // RULE_09
         s_reg.weight   <= WEIGHT_RST;
         s_reg.step     <= WEIGHT_RST;
         s_reg.cur_lim  <= LIM_FULL;
      end else begin
         s_reg <= s_next;
      end
   end

   // Outputs from state flops; multi_channel, station_id_valid and irq through gates
   assign pulse_weight_bypass       = s_reg.logic_in[B_PLS]; // RULE_01
   assign position_bandwidth_select = s_reg.logic_in[B_FN]; // RULE_02
   assign velocity_bandwidth_select = s_reg.logic_in[B_GAIN]; // RULE_03
   assign settling_width_select     =
      s_reg.logic_in[B_POSW1:B_POSW0]; // RULE_04
   assign position_integral_disable = s_reg.logic_in[B_POSITION_INTEGRAL_DISABLE]; // RULE_05
   assign servo_on          = s_reg.servo_on;
   assign error_clear_pulse = s_reg.err_clr;
   assign cmd_step          = s_reg.step;
   assign current_limit     = s_reg.cur_lim;
   assign station_id        = s_reg.id;
   // Zero means point-to-point; any id means ring slave, whatever its
   // place in the ring
   assign multi_channel    =
      s_reg.id_done & (s_reg.id != 4'h0); // RULE_10 RULE_13
   assign station_id_valid = s_reg.id_done & ~s_reg.id_bad;
   assign irq              = |(s_reg.int_stat & s_reg.int_mask);

   // Checks on the block's own outputs
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // Pin-referenced checks see through the sync stages and polarity
   servo_gate_a: assert property (s_reg.id_done |-> servo_on ==
      (($past(servo_on_contact, 3) ^ $past(s_reg.polarity[B_SERVO])) &
       ~$past(panel_servo_disable_switch, 3))) // RULE_08 RULE_15
      else $error("servo on without request or with panel veto");
   bypass_step_a: assert property (s_reg.id_done && pulse_weight_bypass
      |-> cmd_step == STEP_ONE) // RULE_01
      else $error("bypassed pulse does not weigh one");
   step_weight_a: assert property (s_reg.id_done && !pulse_weight_bypass
      |-> cmd_step == $past(s_reg.weight)) // RULE_01
      else $error("weighted pulse does not use the scaling weight");

   pos_bw_a: assert property (s_reg.id_done |->
      position_bandwidth_select == ($past(position_bandwidth_contact, 3)
      ^ $past(s_reg.polarity[B_FN]))) // RULE_02 RULE_15
      else $error("position bandwidth select wrong");
   vel_bw_a: assert property (s_reg.id_done |->
      velocity_bandwidth_select == ($past(velocity_bandwidth_contact, 3)
      ^ $past(s_reg.polarity[B_GAIN]))) // RULE_03 RULE_14
      else $error("velocity bandwidth select wrong");
   settle_sel_a: assert property (s_reg.id_done |->
      settling_width_select == ($past(settling_width_contact, 3)
      ^ $past(s_reg.polarity[B_POSW1:B_POSW0]))) // RULE_04
      else $error("settling width code wrong");
   integral_off_a: assert property (s_reg.id_done |->
      position_integral_disable == ($past(position_integral_contact, 3)
      ^ $past(s_reg.polarity[B_POSITION_INTEGRAL_DISABLE]))) // RULE_05
      else $error("integral disable wrong");
   // Error clear strobes: idle only, requested, single cycle
   clear_idle_a: assert property (error_clear_pulse |->
      $past(drive_idle) ##1 !error_clear_pulse) // RULE_06
      else $error("error clear outside idle or longer than one cycle");
   clear_req_a: assert property (error_clear_pulse |->
      $past(s_reg.logic_in[B_ERR])) // RULE_06
      else $error("error clear without a request");
   clear_busy_a: assert property (!drive_idle |=>
      !error_clear_pulse) // RULE_06
      else $error("error clear issued while busy");
   limit_gate_a: assert property (s_reg.id_done |-> current_limit ==
      ($past(s_reg.lim_en) ? $past(external_current_limit_input)
                           : LIM_FULL)) // RULE_09
      else $error("current limit not gated by enable");
   id_mode_a: assert property (s_reg.id_done && $past(s_reg.id_done) |->
      $stable(station_id) && multi_channel == (station_id != 4'h0)) // RULE_11
      else $error("station id moved or mode wrong");
   id_range_a: assert property (station_id_valid |->
      station_id <= ID_MAX) // RULE_12
      else $error("valid station id above nine");

   // Each event must land in the sticky status at the edge that makes it
   clear_sticky_a: assert property (error_clear_pulse |->
      s_reg.int_stat[EV_CLEAR]) // RULE_06
      else $error("error clear event not recorded");
   servo_event_a: assert property ($changed(servo_on) |->
      s_reg.int_stat[EV_SERVO]) // RULE_08
      else $error("servo change event not recorded");
   sel_event_a: assert property ($changed({settling_width_select,
      velocity_bandwidth_select, position_bandwidth_select}) |->
      s_reg.int_stat[EV_SEL]) // RULE_02 RULE_03 RULE_04
      else $error("selection change event not recorded");

   // Main scenarios the bench should reach
   servo_on_c: cover property (!servo_on ##1 servo_on);
   bad_id_c: cover property (s_reg.id_done && !station_id_valid);
   err_clear_c: cover property (error_clear_pulse);
   multi_mode_c: cover property (multi_channel);
   irq_c: cover property (!irq ##1 irq);
endmodule : srvsel_top

// file: tb/srvsel_plc_model.sv
// Controller model: drives the selector's contact pins from wanted levels.
// Assumes the bench gives levels and error clear requests on pclk edges.
`timescale 1ns/10ps
module srvsel_plc_model (
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic [7:0] lvl,
   input  wire logic       err_go,
   input  wire logic [3:0] err_hold,
   output logic            err_clear_contact,
   output logic            servo_on_contact,
   output logic [1:0]      settling_width_contact,
   output logic            velocity_bandwidth_contact,
   output logic            position_bandwidth_contact,
   output logic            pulse_weight_bypass_contact,
   output logic            position_integral_contact
);
   import srvsel_pkg::*;
   logic [3:0] hold_cnt; // Cycles left on the error clear request
   // Pins follow wanted levels one edge later, like a controller scan
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hold_cnt                    <= 4'h0;
         err_clear_contact           <= 1'b0;
         servo_on_contact            <= 1'b0;
         settling_width_contact      <= 2'h0;
         velocity_bandwidth_contact  <= 1'b0;
         position_bandwidth_contact  <= 1'b0;
         pulse_weight_bypass_contact <= 1'b0;
         position_integral_contact   <= 1'b0;
      end else begin
         servo_on_contact            <= lvl[B_SERVO];
         settling_width_contact      <= lvl[B_POSW1:B_POSW0];
         velocity_bandwidth_contact  <= lvl[B_GAIN];
         position_bandwidth_contact  <= lvl[B_FN];
         pulse_weight_bypass_contact <= lvl[B_PLS];
         position_integral_contact   <= lvl[B_POSITION_INTEGRAL_DISABLE];
         // Request is held a fixed time, never until the error drops
         if (err_go && hold_cnt == 4'h0) begin
            hold_cnt <= err_hold;
         end else if (hold_cnt != 4'h0) begin
            hold_cnt <= hold_cnt - 4'h1;
         end
         err_clear_contact <= (hold_cnt != 4'h0);
      end
   end
endmodule : srvsel_plc_model

// file: tb/tb_servo_input_selector.sv
// Self-checking bench for the servo input selector over APB.
// Assumes zero-wait APB and the model above on the contact pins.
`timescale 1ns/10ps
module tb_servo_input_selector;
   import srvsel_pkg::*;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic        er, err_go, panel, idle, irq;
   logic [7:0]  lvl, lim_in, cur_lim, obs;
   logic [3:0]  hold, id_sw, sid;
   logic [15:0] step;
   logic        c_err, c_srv, c_vel, c_pos, c_pls, c_int;
   logic [1:0]  c_w, w_sel;
   logic        bypass, pos_sel, vel_sel, int_dis, srv, clr, multi, sid_ok;
   int          n_mismatch, comparisons, cyc, n_pulse;
   logic [7:0]  pats [4] = '{8'h00, 8'hA4, 8'h58, 8'hFC};
   logic [3:0]  ids [4] = '{4'h0, 4'h5, 4'h9, 4'hC};
   srvsel_plc_model plc (.pclk(pclk), .presetn(presetn), .lvl(lvl),
      .err_go(err_go), .err_hold(hold), .err_clear_contact(c_err),
      .servo_on_contact(c_srv), .settling_width_contact(c_w),
      .velocity_bandwidth_contact(c_vel),
      .position_bandwidth_contact(c_pos),
      .pulse_weight_bypass_contact(c_pls),
      .position_integral_contact(c_int));
   srvsel_top uut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .err_clear_contact(c_err), .servo_on_contact(c_srv),
      .settling_width_contact(c_w), .velocity_bandwidth_contact(c_vel),
      .position_bandwidth_contact(c_pos),
      .pulse_weight_bypass_contact(c_pls),
      .position_integral_contact(c_int),
      .panel_servo_disable_switch(panel), .station_id_switch(id_sw),
      .drive_idle(idle), .external_current_limit_input(lim_in),
      .pulse_weight_bypass(bypass), .position_bandwidth_select(pos_sel),
      .velocity_bandwidth_select(vel_sel), .settling_width_select(w_sel),
      .position_integral_disable(int_dis), .servo_on(srv),
      .error_clear_pulse(clr), .cmd_step(step), .current_limit(cur_lim),
      .multi_channel(multi), .station_id(sid), .station_id_valid(sid_ok),
      .irq(irq));
   // Logical selections gathered in the STATUS bit layout
   assign obs = {int_dis, bypass, pos_sel, vel_sel, w_sel, srv, 1'b0};
   // 200 MHz clock
   always #2.5 pclk = ~pclk;
   // Pulse counter and hang guard
   always @(posedge pclk) begin
      cyc = cyc + 1;
      if (clr === 1'b1) n_pulse = n_pulse + 1;
      if (cyc > 20000) begin
         n_mismatch = n_mismatch + 1;
         complete_run();
      end
   end
   task automatic wt(input int n);
      repeat (n) @(posedge pclk);
   endtask : wt
   // One APB transfer; only the hang guard ends a wait for pready
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask : apb
   task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                      input string msg);
      comparisons = comparisons + 1;
      if (got !== exp) begin
         n_mismatch = n_mismatch + 1;
         $display("Error at %0t: %s got %h", $time, msg, got);
      end
   endtask : chk
   // Reset held four cycles, then id capture settles
   task automatic do_reset();
      presetn <= 1'b0;
      wt(4);
      presetn <= 1'b1;
      wt(8);
   endtask : do_reset
   task automatic complete_run();
      $display("Mismatches %0d of %0d comparisons", n_mismatch, comparisons);
      if (n_mismatch == 0 && comparisons > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : complete_run
   initial begin
      pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0;
      paddr = 12'h000; pwdata = 32'h0; lvl = 8'h00; err_go = 0;
      hold = 4'h4; panel = 0; idle = 1; lim_in = 8'h40; id_sw = 4'h0;
      n_mismatch = 0; comparisons = 0; cyc = 0; n_pulse = 0;
      do_reset();
      apb(0, CTRL_OFS, 0); chk(rd, 32'h0, "ctrl reset");
      apb(0, WEIGHT_OFS, 0); chk(rd, 32'h1, "weight reset");
      chk(cur_lim, LIM_FULL, "limit off at reset");
      $display("Test reset done");
      // Every width code and each selection both ways, both polarities
      for (int p = 0; p < 2; p++) begin
         apb(1, CTRL_OFS, p ? 32'hFF : 32'h0);
         for (int i = 0; i < 4; i++) begin
            lvl <= pats[i];
            wt(6);
            chk(obs[7:2], pats[i][7:2] ^ {6{p[0]}},
                "sel");
            apb(0, STATUS_OFS, 0);
            chk(rd[7:2], pats[i][7:2] ^ {6{p[0]}}, "stat");
         end
      end
      apb(1, CTRL_OFS, 0);
      $display("Test selections done");
      // Pulse weight follows bypass input
      apb(1, WEIGHT_OFS, 32'h25);
      lvl <= 8'h00; wt(6); chk(step, 16'h0025, "weighted");
      lvl <= 8'h40; wt(6); chk(step, STEP_ONE, "bypass");
      $display("Test weight done");
      // Servo request against panel switch
      for (int k = 0; k < 4; k++) begin
         lvl <= {6'h0, k[0], 1'b0}; panel <= k[1];
         wt(6);
         chk(srv, k[0] & ~k[1], "servo");
      end
      panel <= 1'b0;
      $display("Test servo done");
      // External current limit gated by enable
      apb(1, CTRL_OFS, 32'h100); wt(3);
      chk(cur_lim, 8'h40, "limit on");
      apb(1, CTRL_OFS, 0); wt(3);
      chk(cur_lim, LIM_FULL, "limit off");
      $display("Test limit done");
      // Error clear: idle, busy then idle, busy throughout
      for (int e = 0; e < 3; e++) begin
         n_pulse = 0; idle <= (e == 0); hold <= (e == 1) ? 4'hA : 4'h4;
         @(posedge pclk); err_go <= 1'b1;
         @(posedge pclk); err_go <= 1'b0;
         wt(8); idle <= (e != 2); wt(14);
         idle <= 1'b1; wt(4);
         chk(n_pulse, (e == 2) ? 0 : 1, "clear pulses");
      end
      $display("Test error clear done");
      // Sticky events, mask, W1C clear, unmapped address
      apb(0, INT_STAT_OFS, 0); chk(rd[2:0], 3'h7, "events");
      chk(irq, 1'b0, "masked");
      apb(1, INT_MASK_OFS, 32'h7); wt(1); chk(irq, 1'b1, "irq on");
      apb(1, INT_STAT_OFS, 32'h7); wt(1); chk(irq, 1'b0, "irq clr");
      apb(0, INT_STAT_OFS, 0); chk(rd, 32'h0, "w1c");
      apb(0, 12'h020, 0); chk(er, 1'b1, "unmapped error");
      chk(rd, 32'h0, "unmapped data");
      $display("Test interrupts done");
      // Station id sampled once after reset; ring ids one to nine
      for (int j = 0; j < 4; j++) begin
         id_sw <= ids[j]; do_reset();
         id_sw <= 4'h3; wt(4);
         chk(multi, ids[j] != 4'h0, "multi");
         chk(sid, ids[j], "id held");
         chk(sid_ok, ids[j] <= ID_MAX, "id valid");
      end
      $display("Test station id done");
      complete_run();
   end
endmodule : tb_servo_input_selector
